// File: plpc_link_power.sv
// Purpose: link and power state control with carrier and collision flags
// Assumes: line inputs are asynchronous levels from the analog front end
// Notes: management interface is outside this block and never gated here
`timescale 1ns/10ps
module plpc_link_power #(
  parameter int NOSIG_CYCLES = plpc_pkg::NOSIG_CYC,
  parameter int NEG_CYCLES = plpc_pkg::NEG_WAIT_CYC
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire plpc_pkg::plpc_line_t lineIn,
  input wire plpc_pkg::plpc_mii_t miiIn,
  input wire logic [plpc_pkg::ABIL_W-1:0] localAbil,
  input wire logic autoNegEn,
  input wire logic [plpc_pkg::ABIL_W-1:0] forcedMode,
  input wire logic [15:0] ctlWord,
  input wire logic [15:0] cfgWord,
  output logic crs,
  output logic col,
  output logic linkUp,
  output logic [plpc_pkg::ABIL_W-1:0] activeMode,
  output logic [plpc_pkg::ABIL_W-1:0] advertAbil,
  output logic ackOut,
  output logic flpPulse,
  output logic txEnable,
  output logic rxEnable,
  output logic powerReduced,
  output logic poweredDown,
  output logic sigDetectOn
);
  import plpc_pkg::*;

  // ==========================================================
  // input synchronisers
  plpc_line_t lineMeta_reg, lineSync_reg;
  plpc_mii_t miiMeta_reg, miiSync_reg;
  always_ff @(posedge ref_clk) begin
    lineMeta_reg <= lineIn;
    lineSync_reg <= lineMeta_reg;
    miiMeta_reg <= miiIn;
    miiSync_reg <= miiMeta_reg;
  end

  // ==========================================================
  // decode
  wire pdReq = ctlWord[CTL_POWER_DOWN_BIT];
  wire reduceEn = cfgWord[CFG_PWR_REDUCE_BIT];
  wire validSig = lineSync_reg.flpSeen | lineSync_reg.nlpSeen | lineSync_reg.mlt3Seen;
  wire [ABIL_W-1:0] chosen;
  wire anyCommon;
  plpc_resolve plpc_resolve_inst (
    .localAbil(localAbil),
    .partnerAbil(lineSync_reg.partnerAbil),
    .chosen(chosen),
    .anyCommon(anyCommon)
  );
  // parallel detect classification: mlt3 means 100 half, nlp means 10 half
  wire [ABIL_W-1:0] pdClass = lineSync_reg.mlt3Seen ? 4'h4 : lineSync_reg.nlpSeen ? 4'h1 : 4'h0;
  wire pdMatch = |(pdClass & localAbil);
  wire [ABIL_W-1:0] forcedOk = forcedMode & localAbil;

  plpc_state_t state_reg, state_next;
  logic [CNT_W-1:0] idleCnt_reg, negCnt_reg;
  logic [CNT_W-1:0] flpCnt_reg;
  logic [ABIL_W-1:0] mode_reg, mode_next;
  wire idleExpired = idleCnt_reg >= CNT_W'(NOSIG_CYCLES - 1);
  wire negExpired = negCnt_reg >= CNT_W'(NEG_CYCLES - 1);
  wire sigLost = idleExpired & reduceEn;
  wire fullDuplex = mode_reg[ABIL_10FD] | mode_reg[ABIL_100FD];

  // ==========================================================
  // state selection
  always_comb begin
    state_next = state_reg;
    mode_next = mode_reg;
    case (state_reg)
      ST_DOWN: begin
        if (autoNegEn) begin
          state_next = ST_NEGOTIATE;
        end else if (|forcedOk) begin
          state_next = ST_LINKED;
          mode_next = forcedOk;
        end
      end
      ST_NEGOTIATE: begin
        if (sigLost) begin
          state_next = ST_REDUCED;
        end else if (lineSync_reg.partnerAck && anyCommon) begin
          state_next = ST_LINKED;
          mode_next = chosen;
        end else if (!lineSync_reg.flpSeen && validSig) begin
          state_next = ST_PARALLEL;
        end else if (negExpired) begin
          state_next = ST_DOWN;
        end
      end
      ST_PARALLEL: begin
        if (pdMatch) begin
          state_next = ST_LINKED;
          mode_next = pdClass;
        end else if (sigLost) begin
          state_next = ST_REDUCED;
        end else if (lineSync_reg.flpSeen) begin
          state_next = ST_NEGOTIATE;
        end
      end
      ST_LINKED: begin
        if (sigLost) begin
          state_next = ST_REDUCED;
          mode_next = '0;
        end
      end
      ST_REDUCED: begin
        if (validSig || !reduceEn) begin
          state_next = ST_DOWN;
        end
      end
      ST_SLEEP: begin
        state_next = ST_DOWN;
        mode_next = '0;
      end
      default: begin
        state_next = ST_DOWN;
        mode_next = '0;
      end
    endcase
    if (pdReq) begin
      state_next = ST_SLEEP;
      mode_next = '0;
    end
  end

  // ==========================================================
  // state and counters
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_reg <= ST_DOWN;
      mode_reg <= '0;
    end else begin
      state_reg <= state_next;
      mode_reg <= mode_next;
    end
  end

  // idle counter restarts on any line signal; sig detect never gated
  always_ff @(posedge ref_clk) begin
    if (reset || lineSync_reg.sigDetect || validSig || state_reg == ST_SLEEP) begin
      idleCnt_reg <= '0;
    end else if (!idleExpired) begin
      idleCnt_reg <= idleCnt_reg + 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset || state_reg != ST_NEGOTIATE) begin
      negCnt_reg <= '0;
    end else begin
      negCnt_reg <= negCnt_reg + 1'b1;
    end
  end

  // flp burst timer keeps running in reduced state
  wire flpDue = flpCnt_reg == CNT_W'(FLP_GAP_CYC - 1);
  wire flpState = state_reg == ST_NEGOTIATE || state_reg == ST_REDUCED;
  always_ff @(posedge ref_clk) begin
    if (reset || flpDue || !flpState) begin
      flpCnt_reg <= '0;
    end else begin
      flpCnt_reg <= flpCnt_reg + 1'b1;
    end
  end

  // ==========================================================
  // outputs
  wire linked = state_reg == ST_LINKED;
  wire txA = miiSync_reg.txActive & linked; // data paths off unless linked
  wire rxA = miiSync_reg.rxActive & linked;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      crs <= 1'b0;
      col <= 1'b0;
      linkUp <= 1'b0;
      activeMode <= '0;
      advertAbil <= '0;
      ackOut <= 1'b0;
      flpPulse <= 1'b0;
      txEnable <= 1'b0;
      rxEnable <= 1'b0;
      powerReduced <= 1'b0;
      poweredDown <= RST_POWER_DOWN;
      sigDetectOn <= 1'b1;
    end else begin
      crs <= fullDuplex ? rxA : (txA | rxA);
      col <= !fullDuplex & txA & rxA;
      linkUp <= linked;
      activeMode <= mode_reg;
      advertAbil <= (state_reg == ST_NEGOTIATE) ? localAbil : '0;
      ackOut <= (state_reg == ST_NEGOTIATE) & anyCommon;
      flpPulse <= flpDue & flpState;
      txEnable <= linked;
      rxEnable <= linked;
      powerReduced <= state_reg == ST_REDUCED;
      poweredDown <= state_reg == ST_SLEEP;
      sigDetectOn <= 1'b1;
    end
  end

  // ==========================================================
  // assertions
  property p_crsFull;
    @(posedge ref_clk) disable iff (reset) fullDuplex && !rxA |=> !crs;
  endproperty
  a_crsFull: assert property (p_crsFull) else $error("full duplex carrier without rx");
  property p_crsHalf;
    @(posedge ref_clk) disable iff (reset) !fullDuplex && txA |=> crs;
  endproperty
  a_crsHalf: assert property (p_crsHalf) else $error("half duplex tx without carrier");
  property p_col;
    @(posedge ref_clk) disable iff (reset) fullDuplex |=> !col;
  endproperty
  a_col: assert property (p_col) else $error("collision in full duplex");
  property p_pd;
    @(posedge ref_clk) disable iff (reset) pdReq |=> ##1 poweredDown && !txEnable;
  endproperty
  a_pd: assert property (p_pd) else $error("power down not entered");
  property p_pdPaths;
    @(posedge ref_clk) disable iff (reset) poweredDown |-> !crs && !rxEnable;
  endproperty
  a_pdPaths: assert property (p_pdPaths) else $error("data path alive in power down");
  // detection must still restart the idle count in every state, reduced and asleep too
  property p_sd;
    @(posedge ref_clk) disable iff (reset)
      lineSync_reg.sigDetect |=> idleCnt_reg == '0 && sigDetectOn;
  endproperty
  a_sd: assert property (p_sd) else $error("signal detect off");
  property p_wake;
    @(posedge ref_clk) disable iff (reset)
      state_reg == ST_REDUCED && validSig && !pdReq |=> state_reg == ST_DOWN;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on valid signal");
  property p_noReduce;
    @(posedge ref_clk) disable iff (reset) !reduceEn |=> ##1 !powerReduced;
  endproperty
  a_noReduce: assert property (p_noReduce) else $error("reduced while disabled");
  property p_resume;
    @(posedge ref_clk) disable iff (reset)
      state_reg == ST_SLEEP && !pdReq |=> state_reg == ST_DOWN;
  endproperty
  a_resume: assert property (p_resume) else $error("no resume after power down");
  property p_onehot;
    @(posedge ref_clk) disable iff (reset) linked |-> $onehot(mode_reg);
  endproperty
  a_onehot: assert property (p_onehot) else $error("link mode not single");
endmodule // plpc_link_power

// File: plpc_link_power_tb.sv
// Purpose: self-checking bench for link and power control
// Assumes: shortened no-signal and negotiation counts
// Notes: inputs change 1 ns after the rising edge
`timescale 1ns/10ps
module plpc_link_power_tb;
  import plpc_pkg::*;
  localparam int NOSIG_SIM = 20;
  localparam int NEG_SIM = 40;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  plpc_line_t lineIn;
  plpc_mii_t miiIn = '0;
  logic [3:0] localAbil = 4'hf;
  logic autoNegEn = 1'b1;
  logic [3:0] forcedMode = 4'h1;
  logic [15:0] ctlWord = 16'h0000;
  logic [15:0] cfgWord = 16'h0010;
  logic [1:0] kind = 2'h1;
  logic [3:0] abil = 4'h5;
  logic [7:0] ackDly = 8'h1e;
  logic crs, col, linkUp, ackOut, flpPulse, txEnable, rxEnable;
  logic powerReduced, poweredDown, sigDetectOn;
  logic [3:0] activeMode, advertAbil;
  int fails = 0;
  int checked = 0;
  int n;
  // ==========================================
  // design and far side
  plpc_link_power #(.NOSIG_CYCLES(NOSIG_SIM), .NEG_CYCLES(NEG_SIM)) plpc_link_power_inst (
    .ref_clk(ref_clk), .reset(reset), .lineIn(lineIn), .miiIn(miiIn), .localAbil(localAbil),
    .autoNegEn(autoNegEn), .forcedMode(forcedMode), .ctlWord(ctlWord), .cfgWord(cfgWord),
    .crs(crs), .col(col), .linkUp(linkUp), .activeMode(activeMode), .advertAbil(advertAbil),
    .ackOut(ackOut), .flpPulse(flpPulse), .txEnable(txEnable), .rxEnable(rxEnable),
    .powerReduced(powerReduced), .poweredDown(poweredDown), .sigDetectOn(sigDetectOn));
  plpc_partner plpc_partner_inst (.ref_clk(ref_clk), .kind(kind), .abil(abil),
    .ackDly(ackDly), .advertAbil(advertAbil), .lineOut(lineIn));
  always #10 ref_clk = ~ref_clk;
  // ==========================================
  // helpers
  task automatic tick(int cnt = 1);
    repeat (cnt) begin
      @(posedge ref_clk);
      #1;
    end
  endtask
  task automatic check_bit(string what, logic exp, logic got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic check_nib(string what, logic [3:0] exp, logic [3:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  // fresh start so every scenario begins again from the down state
  task automatic restart(logic [1:0] k, logic [3:0] a);
    kind = k;
    abil = a;
    reset = 1'b1;
    tick(2);
    reset = 1'b0;
  endtask
  task automatic relink(logic [1:0] k, logic [3:0] a);
    restart(k, a);
    for (n = 0; n < 400 && linkUp !== 1'b1; n++) tick();
  endtask
  // crs and col settle three edges after the mii levels
  task automatic mii(logic tx, logic rx, logic c, logic k);
    miiIn.txActive = tx;
    miiIn.rxActive = rx;
    tick(4);
    check_bit("crs", c, crs);
    check_bit("col", k, col);
  endtask
  // ==========================================
  // scenarios
  task automatic test_duplex();
    // advertisement only stands while negotiating, so look before the link comes up
    restart(2'h1, 4'h5);
    tick(3);
    check_nib("advert", 4'hf, advertAbil);
    check_bit("ack", 1'b1, ackOut);
    for (n = 0; n < 400 && linkUp !== 1'b1; n++) tick();
    check_bit("link", 1'b1, linkUp);
    check_nib("mode", 4'h4, activeMode);
    mii(1'b1, 1'b0, 1'b1, 1'b0);
    mii(1'b1, 1'b1, 1'b1, 1'b1);
    mii(1'b0, 1'b0, 1'b0, 1'b0);
    ackDly = 8'h00;
    relink(2'h1, 4'hb);
    check_nib("mode", 4'h8, activeMode);
    mii(1'b1, 1'b0, 1'b0, 1'b0);
    mii(1'b1, 1'b1, 1'b1, 1'b0);
    mii(1'b0, 1'b0, 1'b0, 1'b0);
    // nothing shared: no acknowledge and no link
    localAbil = 4'h3;
    restart(2'h1, 4'hc);
    tick(30);
    check_bit("ack unshared", 1'b0, ackOut);
    check_bit("link unshared", 1'b0, linkUp);
    localAbil = 4'hf;
  endtask
  task automatic test_parallel();
    relink(2'h3, 4'h0);
    check_bit("link", 1'b1, linkUp);
    check_nib("mode", 4'h4, activeMode);
    relink(2'h2, 4'h0);
    check_nib("mode", 4'h1, activeMode);
  endtask
  task automatic test_reduced();
    relink(2'h1, 4'h5);
    kind = 2'h0;
    for (n = 0; n < 200 && powerReduced !== 1'b1; n++) tick();
    check_bit("reduced", 1'b1, powerReduced);
    check_bit("detect", 1'b1, sigDetectOn);
    for (n = 0; n < 900 && flpPulse !== 1'b1; n++) tick();
    check_bit("flp", 1'b1, flpPulse);
    kind = 2'h2;
    tick(20);
    check_bit("reduced", 1'b0, powerReduced);
    check_bit("resume", 1'b1, linkUp);
    autoNegEn = 1'b0;
    relink(2'h2, 4'h0);
    kind = 2'h0;
    for (n = 0; n < 200 && powerReduced !== 1'b1; n++) tick();
    check_bit("forced reduced", 1'b1, powerReduced);
    autoNegEn = 1'b1;
    cfgWord = 16'h0000;
    relink(2'h1, 4'h5);
    kind = 2'h0;
    tick(200);
    check_bit("reduced off", 1'b0, powerReduced);
    cfgWord = 16'h0010;
  endtask
  task automatic test_power_down();
    relink(2'h1, 4'h5);
    check_bit("tx on", 1'b1, txEnable);
    ctlWord = 16'h0800;
    tick(5);
    check_bit("down", 1'b1, poweredDown);
    check_bit("link", 1'b0, linkUp);
    check_bit("tx", 1'b0, txEnable);
    check_bit("rx", 1'b0, rxEnable);
    mii(1'b1, 1'b1, 1'b0, 1'b0);
    miiIn = '0;
    ctlWord = 16'h0000;
    for (n = 0; n < 400 && linkUp !== 1'b1; n++) tick();
    check_bit("down", 1'b0, poweredDown);
    check_bit("relink", 1'b1, linkUp);
  endtask
  task automatic wrap_up();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ==========================================
  // main sequence
  initial begin
    tick(2);
    reset = 1'b0;
    test_duplex();
    test_parallel();
    test_reduced();
    test_power_down();
    wrap_up();
  end
  // watchdog: about 1300 cycles expected, limit of 20000 is over fifteen times that
  initial begin
    #400000;
    fails++;
    wrap_up();
  end
endmodule // plpc_link_power_tb

// File: plpc_partner.sv
// Purpose: remote link partner on the cable, seen as line indications
// Assumes: kind 0 cable off, 1 negotiating, 2 10 Mb/s link pulses, 3 100 Mb/s activity
// Notes: ack is held back ackDly cycles after our advertisement shows
`timescale 1ns/10ps
module plpc_partner (
  input wire logic ref_clk,
  input wire logic [1:0] kind,
  input wire logic [3:0] abil,
  input wire logic [7:0] ackDly,
  input wire logic [3:0] advertAbil,
  output plpc_pkg::plpc_line_t lineOut
);
  import plpc_pkg::*;
  logic [7:0] waitCnt_reg;
  // only modes both ends hold may be acknowledged
  wire shared = |(abil & advertAbil);
  // ==========================================
  // how long our advertisement has been visible
  always @(posedge ref_clk) begin
    if (kind != 2'h1 || advertAbil == 4'h0) waitCnt_reg <= 8'h00;
    else if (waitCnt_reg != 8'hff) waitCnt_reg <= waitCnt_reg + 8'h01;
  end
  // ==========================================
  // line levels; a non-negotiating partner sends no configuration
  always_comb begin
    lineOut = '0;
    lineOut.sigDetect = (kind != 2'h0);
    lineOut.flpSeen = (kind == 2'h1);
    lineOut.nlpSeen = (kind == 2'h2);
    lineOut.mlt3Seen = (kind == 2'h3);
    if (kind == 2'h1) lineOut.partnerAbil = abil;
    // no ack before an advertisement was received, even with zero delay
    lineOut.partnerAck = (kind == 2'h1) && shared && (waitCnt_reg >= ackDly);
  end
endmodule // plpc_partner

// File: plpc_pkg.sv
// Purpose: shared constants and types for the phy link and power control block
// Assumes: one 50 MHz clock, synchronous active-high reset
// Notes: line indications come from the analog front end as plain levels
// Notes on behaviour
// - half duplex: carrier on transmit or receive
// - full duplex: carrier only on receive
// - advertise, acknowledge common, reject unshared modes
// - pick highest-priority common mode, exactly one
// - non-negotiating partner: classify line signal instead
// - matching detected technology brings link up
// - signal detect stays on, even power reduced
// - no signal enters power-reduced state automatically
// - power reduced still sends fast link pulses
// - valid line signal wakes to normal operation
// - control bit zero disables automatic power reduction
// - power-down bit one enters power down
// - power down stops data paths, keeps management
// - half duplex collision flag; none in full
package plpc_pkg;
  // ability bits, index = priority (3 highest)
  localparam int ABIL_W = 4;
  localparam logic [1:0] ABIL_10HD = 2'h0;
  localparam logic [1:0] ABIL_10FD = 2'h1;
  localparam logic [1:0] ABIL_100HD = 2'h2;
  localparam logic [1:0] ABIL_100FD = 2'h3;
  // control bit positions
  localparam int CTL_POWER_DOWN_BIT = 11;
  localparam int CFG_PWR_REDUCE_BIT = 4;
  localparam logic RST_PWR_REDUCE_EN = 1'b1;
  localparam logic RST_POWER_DOWN = 1'b0;
  // timing
  localparam int CLK_MHZ = 50;
  localparam int NOSIG_US = 1000;
  localparam int NOSIG_CYC = NOSIG_US * CLK_MHZ;
  localparam int FLP_GAP_US = 16;
  localparam int FLP_GAP_CYC = FLP_GAP_US * CLK_MHZ;
  localparam int NEG_WAIT_US = 2000;
  localparam int NEG_WAIT_CYC = NEG_WAIT_US * CLK_MHZ;
  localparam int CNT_W = 24;

  typedef enum logic [5:0] {
    ST_DOWN = 6'h01,
    ST_NEGOTIATE = 6'h02,
    ST_PARALLEL = 6'h04,
    ST_LINKED = 6'h08,
    ST_REDUCED = 6'h10,
    ST_SLEEP = 6'h20
  } plpc_state_t;

  // line-side indications
  typedef struct packed {
    logic sigDetect;
    logic flpSeen;
    logic nlpSeen;
    logic mlt3Seen;
    logic [3:0] partnerAbil;
    logic partnerAck;
  } plpc_line_t;

  // mii-side activity
  typedef struct packed {
    logic txActive;
    logic rxActive;
  } plpc_mii_t;
endpackage

// File: plpc_resolve.sv
// Purpose: priority resolution of common abilities
// Assumes: bit index equals priority
// Notes: result is one-hot, zero when nothing shared
`timescale 1ns/10ps
module plpc_resolve (
  input wire logic [plpc_pkg::ABIL_W-1:0] localAbil,
  input wire logic [plpc_pkg::ABIL_W-1:0] partnerAbil,
  output logic [plpc_pkg::ABIL_W-1:0] chosen,
  output logic anyCommon
);
  import plpc_pkg::*;
  wire [ABIL_W-1:0] common = localAbil & partnerAbil; // unshared modes rejected
  // highest set bit wins
  assign chosen = common[3] ? 4'h8 : common[2] ? 4'h4 : common[1] ? 4'h2 : common[0] ? 4'h1
    : 4'h0;
  assign anyCommon = |common;
endmodule // plpc_resolve
